// *** design/mad_consts.svh ***
// constants of the microcode execution datapath: field positions, codes, bit positions, reset values
// assumes nothing; included by the package and by the design files
`ifndef MAD_CONSTS_SVH
`define MAD_CONSTS_SVH

// instruction word fields
`define MAD_F_HI 15
`define MAD_F_LO 12
`define MAD_D_HI 11
`define MAD_D_LO 8
`define MAD_S_HI 7
`define MAD_S_LO 4
`define MAD_M_HI 3
`define MAD_M_LO 0
`define MAD_K_HI 7
`define MAD_K_LO 0

// mode bits
`define MAD_M_UPD 3
`define MAD_M_OPT 2

// function codes
`define MAD_FN_TRANSFER 4'h0
`define MAD_FN_JUMP 4'h1
`define MAD_FN_SHIFT 4'h3
`define MAD_FN_ADD 4'h4
`define MAD_FN_SUB 4'h5
`define MAD_FN_LOG1 4'h6
`define MAD_FN_LOG2 4'h7
`define MAD_FN_ADDK 4'h8
`define MAD_FN_SUBK 4'h9
`define MAD_FN_LDK1 4'hA
`define MAD_FN_LDK2 4'hB
`define MAD_FN_BRANCH 4'hC

// carry options in mode bits 1-0
`define MAD_CY_FORCE 2'h0
`define MAD_CY_HOLD 2'h1
`define MAD_CY_EAC 2'h2
`define MAD_CY_NONE 2'h3

// shift fill codes in mode bits 1-0
`define MAD_FILL_ZERO 2'h0
`define MAD_FILL_SIGN 2'h1
`define MAD_FILL_SAVE 2'h2
`define MAD_FILL_SER 2'h3

// selector codes
`define MAD_S1_EXT_LAST 4'h6
`define MAD_S1_CHECK 4'h7
`define MAD_S2_HOLD 4'h0
`define MAD_S2_CONDITION_FLAGS_REGISTER 4'h1
`define MAD_S2_DISP 4'h2
`define MAD_S2_CONSOLE 4'h3
`define MAD_D2_ADDR 4'h0
`define MAD_D2_CONDITION_FLAGS_REGISTER 4'h1
`define MAD_D2_DISP 4'h2
`define MAD_D2_CYC 4'h3
`define MAD_D2_CHECK 4'h8
`define MAD_ACC_BIT 3

// condition register bits
`define MAD_C_SHSAVE 15
`define MAD_C_POS 14
`define MAD_C_ZERO 13
`define MAD_C_CARRY 10

// branch selectors
`define MAD_BR_POS 4'h0
`define MAD_BR_ZERO 4'h1
`define MAD_BR_CARRY 4'h4
`define MAD_BR_SHSAVE 4'h7
`define MAD_BR_NZERO 4'h8
`define MAD_BR_CYCFULL 4'h9
`define MAD_BR_PAREVEN 4'hA
`define MAD_BR_NREADY 4'hB
`define MAD_BR_ZFRAME 4'hC
`define MAD_BR_READY 4'hD
`define MAD_BR_TRUE 4'hE
`define MAD_BR_FALSE 4'hF

// reset values
`define MAD_RST_WORD 16'h0000
`define MAD_RST_BIT 1'b0

`endif

// *** design/mad_pkg.sv ***
// types of the microcode execution datapath
// assumes mad_consts.svh on the include path
`include "mad_consts.svh"

package mad_pkg;
    typedef logic [15:0] mad_word_t;

    typedef enum logic [3:0] {
        MAD_TRANSFER = `MAD_FN_TRANSFER,
        MAD_JUMP = `MAD_FN_JUMP,
        MAD_SHIFT = `MAD_FN_SHIFT,
        MAD_ADD = `MAD_FN_ADD,
        MAD_SUB = `MAD_FN_SUB,
        MAD_LOG1 = `MAD_FN_LOG1,
        MAD_LOG2 = `MAD_FN_LOG2,
        MAD_ADDK = `MAD_FN_ADDK,
        MAD_SUBK = `MAD_FN_SUBK,
        MAD_LDK1 = `MAD_FN_LDK1,
        MAD_LDK2 = `MAD_FN_LDK2,
        MAD_BRANCH = `MAD_FN_BRANCH
    } mad_fn_t;
endpackage

// *** design/mad_alu_if.sv ***
// operand and result bundle between the datapath controller and its arithmetic unit
// assumes mad_pkg compiled first
`timescale 1ns/1ps

interface mad_alu_if;
    import mad_pkg::*;
    logic [3:0] fn;
    logic [3:0] mode;
    logic [7:0] konst;
    mad_word_t src;
    mad_word_t acc;
    logic carry_hold;
    logic shift_save;
    logic serial_in;
    mad_word_t result;
    logic carry;
    logic shift_out;

    modport ctl (output fn, mode, konst, src, acc, carry_hold, shift_save, serial_in,
                 input result, carry, shift_out);
    modport alu (input fn, mode, konst, src, acc, carry_hold, shift_save, serial_in,
                 output result, carry, shift_out);
endinterface

// *** design/mad_alu.sv ***
// combinational arithmetic, logic, shift and transfer unit of the execution datapath
// assumes the controller has already picked the source word and the implicit accumulator
`timescale 1ns/1ps
`include "mad_consts.svh"

module mad_alu (
    mad_alu_if.alu bus
);
    import mad_pkg::*;

    wire [3:0] m = bus.mode;
    wire [15:0] s = bus.src;
    wire [15:0] a = bus.acc;
    wire [15:0] k16 = {8'h00, bus.konst};

    // transfer, rotated by a byte when asked
    wire [15:0] xfer = m[`MAD_M_OPT] ? {s[7:0], s[15:8]} : s;

    // shift by one with the four fill options; the save bit comes from the previous shift
    wire fill = (m[1:0] == `MAD_FILL_ZERO) ? 1'b0 :
                (m[1:0] == `MAD_FILL_SIGN) ? (m[`MAD_M_OPT] ? s[15] : s[15]) :
                (m[1:0] == `MAD_FILL_SAVE) ? bus.shift_save : bus.serial_in;
    wire [15:0] shl = {s[14:0], fill};
    wire [15:0] shr = {fill, s[15:1]};
    wire sh_out = m[`MAD_M_OPT] ? s[0] : s[15];

    // add and subtract share one adder; subtract adds the complemented source
    wire is_sub = (bus.fn == `MAD_FN_SUB);
    wire [15:0] add_x = m[`MAD_M_OPT] ? {16{m[0]}} : a;
    wire [15:0] sub_x = m[`MAD_M_OPT] ? `MAD_RST_WORD : a;
    wire [15:0] op_x = is_sub ? sub_x : add_x;
    wire [15:0] op_y = is_sub ? ~s : s;
    wire eac = (m[1:0] == `MAD_CY_EAC);
    wire cin = (m[1:0] == `MAD_CY_FORCE) ? 1'b1 :
               (m[1:0] == `MAD_CY_HOLD) ? bus.carry_hold : 1'b0;
    wire [16:0] raw = {1'b0, op_x} + {1'b0, op_y} + {16'h0000, cin};
    // end-around carry feeds the carry out back in; one pass cannot ripple out again
    wire [15:0] arith = raw[15:0] + {15'h0000, eac & raw[16]};

    // constant forms work on the accumulator alone
    wire [16:0] addk = {1'b0, a} + {1'b0, k16};
    wire [16:0] subk = {1'b0, a} + {1'b0, ~k16} + 17'h00001;

    // the two logic groups as eight-entry selections on mode bits 2-0
    wire [15:0] lg1 [8];
    wire [15:0] lg2 [8];
    assign lg1[0] = a ^ s;
    assign lg1[1] = ~(a & s);
    assign lg1[2] = a & ~s;
    assign lg1[3] = ~s;
    assign lg1[4] = a | s;
    assign lg1[5] = 16'hFFFF;
    assign lg1[6] = a;
    assign lg1[7] = a | ~s;
    assign lg2[0] = ~a & s;
    assign lg2[1] = ~a;
    assign lg2[2] = 16'h0000;
    assign lg2[3] = ~(a | s);
    assign lg2[4] = s;
    assign lg2[5] = ~a | s;
    assign lg2[6] = a & s;
    assign lg2[7] = ~(a ^ s);

    // result selection by function code
    assign bus.result = (bus.fn == `MAD_FN_TRANSFER) ? xfer :
                        (bus.fn == `MAD_FN_SHIFT) ? (m[`MAD_M_OPT] ? shr : shl) :
                        (bus.fn == `MAD_FN_ADD || is_sub) ? arith :
                        (bus.fn == `MAD_FN_LOG1) ? lg1[m[2:0]] :
                        (bus.fn == `MAD_FN_LOG2) ? lg2[m[2:0]] :
                        (bus.fn == `MAD_FN_ADDK) ? addk[15:0] :
                        (bus.fn == `MAD_FN_SUBK) ? subk[15:0] : k16;
    assign bus.carry = (bus.fn == `MAD_FN_ADD || is_sub) ? raw[16] :
                       (bus.fn == `MAD_FN_ADDK) ? addk[16] :
                       (bus.fn == `MAD_FN_SUBK) ? subk[16] : bus.carry_hold;
    assign bus.shift_out = sh_out;
endmodule

// *** design/mad_datapath.sv ***
// execution datapath of a 16-bit microprogrammed controller: decode, register file, branch
// assumes one instruction word per instr_valid_i cycle and external regs on the same clock
// Overview of operation
// - word splits into function 15-12, destination 11-8, source 7-4, mode 3-0
// - primary source codes 0-6 select the seven external source registers
// - primary destinations 0-7 external registers, 10-17 octal accumulators
// - condition flags update only when mode bit 3 is set; a write to secondary destination 1 loads the register whatever the mode
// - transfer with mode bit 2 rotates the word left by eight
// - shift moves one place, left on mode bit 2 clear, right when set
// - fill 00 zero, 01 sign or circular, 11 serial input
// - fill 10 inserts the bit shifted out by the previous shift
// - add source plus accumulator with four carry options, bit 2 fixed operand
// - subtract source from accumulator, same carries, bit 2 uses positive zero
// - logic one codes 0-3: xor, nand, and-not, not source
// - logic one codes 4-7: or, all ones, accumulator, or-not
// - logic two codes 0-3: not-acc and, not acc, zeros, nor
// - logic two codes 4-7: source, not-acc or, and, xnor
// - add constant adds the low byte to the accumulator
// - subtract constant takes the low byte from the accumulator
// - constant to primary destination clears bits above the low eight
// - constant to secondary destination clears higher bits
// - taken branch saves address to hold, replaces address low byte
// - untaken branch steps the whole 16-bit address on, hold untouched
// - branch positive tests condition bit 14, zero tests bit 13
// - branch carry tests bit 10, shift save tests bit 15
// - more selectors: not zero, cycle full, parity even, no frame, zero frame
// - last selectors: frame read, last test true, last test false
`timescale 1ns/1ps
`include "mad_consts.svh"

module mad_datapath #(
    parameter int WIDTH = 16
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic instr_valid_i,
    input wire mad_pkg::mad_word_t instr_i,
    input wire logic [6:0][15:0] prim_src_i,
    input wire mad_pkg::mad_word_t console_mode_i,
    input wire logic serial_in_i,
    input wire logic parity_even_i,
    input wire logic frame_ready_i,
    input wire logic zero_frame_i,
    input wire logic test_true_i,
    output logic [7:0] prim_dst_wr_o,
    output mad_pkg::mad_word_t prim_dst_data_o,
    output mad_pkg::mad_word_t instr_addr_o,
    output mad_pkg::mad_word_t hold_o,
    output mad_pkg::mad_word_t condition_flags_register_o,
    output mad_pkg::mad_word_t display_o,
    output mad_pkg::mad_word_t cycle_count_o,
    output mad_pkg::mad_word_t check_o
);
    import mad_pkg::*;

    mad_alu_if alu_bus ();

    mad_alu u_alu (
        .bus(alu_bus)
    );

    // instruction fields
    wire [3:0] fn = instr_i[`MAD_F_HI:`MAD_F_LO];
    wire [3:0] dcode = instr_i[`MAD_D_HI:`MAD_D_LO];
    wire [3:0] scode = instr_i[`MAD_S_HI:`MAD_S_LO];
    wire [3:0] mode = instr_i[`MAD_M_HI:`MAD_M_LO];
    wire [7:0] konst = instr_i[`MAD_K_HI:`MAD_K_LO];

    // state
    mad_word_t acc_r [8];
    mad_word_t condition_flags_register_r;
    mad_word_t disp_r;
    logic [WIDTH-1:0] cyc_r;
    mad_word_t check_r;
    mad_word_t addr_r;
    mad_word_t hold_r;
    logic shsave_r;
    logic [7:0] dwr_r;
    mad_word_t ddata_r;

    // function class decode
    wire is_xfer = (fn == `MAD_FN_TRANSFER);
    wire is_shift = (fn == `MAD_FN_SHIFT);
    wire is_branch = (fn == `MAD_FN_BRANCH);
    wire is_ldk2 = (fn == `MAD_FN_LDK2);
    wire upd_class = is_xfer || is_shift || (fn >= `MAD_FN_ADD && fn <= `MAD_FN_LOG2);
    wire prim_class = upd_class || (fn >= `MAD_FN_ADDK && fn <= `MAD_FN_LDK1);
    wire to_sec = (is_xfer && mode[1]) || is_ldk2;
    wire to_prim = prim_class && !(is_xfer && mode[1]);
    wire use_s2 = is_xfer && mode[0];

    // primary source selection; codes above 7 read the accumulators
    wire [15:0] s1_word = scode[`MAD_ACC_BIT] ? acc_r[scode[2:0]] :
                          (scode == `MAD_S1_CHECK) ? check_r : prim_src_i[scode[2:0]];
    wire [15:0] s2_word = (scode == `MAD_S2_HOLD) ? hold_r :
                          (scode == `MAD_S2_CONDITION_FLAGS_REGISTER) ? condition_flags_register_r :
                          (scode == `MAD_S2_DISP) ? disp_r :
                          (scode == `MAD_S2_CONSOLE) ? console_mode_i : `MAD_RST_WORD;

    // operands to the arithmetic unit; the first accumulator is always the second operand
    assign alu_bus.fn = fn;
    assign alu_bus.mode = mode;
    assign alu_bus.konst = konst;
    assign alu_bus.src = use_s2 ? s2_word : s1_word;
    assign alu_bus.acc = acc_r[0];
    assign alu_bus.carry_hold = condition_flags_register_r[`MAD_C_CARRY];
    assign alu_bus.shift_save = shsave_r;
    assign alu_bus.serial_in = serial_in_i;
    wire [15:0] res = alu_bus.result;

    // destination decode
    wire wr_prim = instr_valid_i && to_prim;
    wire wr_sec = instr_valid_i && to_sec;
    wire wr_acc = wr_prim && dcode[`MAD_ACC_BIT];
    wire wr_ext = wr_prim && !dcode[`MAD_ACC_BIT];
    wire wr_addr = wr_sec && (dcode == `MAD_D2_ADDR);
    wire wr_condition_flags_register = wr_sec && (dcode == `MAD_D2_CONDITION_FLAGS_REGISTER);
    wire wr_disp = wr_sec && (dcode == `MAD_D2_DISP);
    wire wr_cyc = wr_sec && (dcode == `MAD_D2_CYC);
    wire wr_check = wr_sec && (dcode == `MAD_D2_CHECK);

    // condition flags from the result; the shift save bit follows the latest shift
    wire shsave_nxt = (instr_valid_i && is_shift) ? alu_bus.shift_out : shsave_r;
    wire upd = instr_valid_i && upd_class && mode[`MAD_M_UPD];
    wire [15:0] condition_flags_register_flags = {shsave_nxt, ~res[15], (res == `MAD_RST_WORD), condition_flags_register_r[12:11],
                              alu_bus.carry, condition_flags_register_r[9:0]};
    // an explicit write to the condition register overrides the flag update
    wire [15:0] condition_flags_register_nxt = wr_condition_flags_register ? res : (upd ? condition_flags_register_flags : condition_flags_register_r);

    // branch condition selection
    wire [15:0] bsel;
    assign bsel[`MAD_BR_POS] = condition_flags_register_r[`MAD_C_POS];
    assign bsel[`MAD_BR_ZERO] = condition_flags_register_r[`MAD_C_ZERO];
    assign bsel[2] = 1'b0;
    assign bsel[3] = 1'b0;
    assign bsel[`MAD_BR_CARRY] = condition_flags_register_r[`MAD_C_CARRY];
    assign bsel[5] = 1'b0;
    assign bsel[6] = 1'b0;
    assign bsel[`MAD_BR_SHSAVE] = condition_flags_register_r[`MAD_C_SHSAVE];
    assign bsel[`MAD_BR_NZERO] = !condition_flags_register_r[`MAD_C_ZERO];
    assign bsel[`MAD_BR_CYCFULL] = &cyc_r;
    assign bsel[`MAD_BR_PAREVEN] = parity_even_i;
    assign bsel[`MAD_BR_NREADY] = !frame_ready_i;
    assign bsel[`MAD_BR_ZFRAME] = zero_frame_i;
    assign bsel[`MAD_BR_READY] = frame_ready_i;
    assign bsel[`MAD_BR_TRUE] = test_true_i;
    assign bsel[`MAD_BR_FALSE] = !test_true_i;
    wire taken = instr_valid_i && is_branch && bsel[dcode];

    // next instruction address: branch, secondary write, or sequential step
    wire [15:0] addr_step = addr_r + 16'h0001;
    wire [15:0] addr_nxt = taken ? {addr_r[15:8], konst} :
                           wr_addr ? res :
                           instr_valid_i ? addr_step : addr_r;

    // accumulators, one register per entry
    for (genvar i = 0; i < 8; i++) begin : g_acc
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                acc_r[i] <= `MAD_RST_WORD;
            end else if (wr_acc && dcode[2:0] == 3'(i)) begin
                acc_r[i] <= res;
            end
        end
    end

    // control words and sequencing
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            condition_flags_register_r <= `MAD_RST_WORD;
            addr_r <= `MAD_RST_WORD;
            hold_r <= `MAD_RST_WORD;
            shsave_r <= `MAD_RST_BIT;
        end else begin
            condition_flags_register_r <= condition_flags_register_nxt;
            addr_r <= addr_nxt;
            shsave_r <= shsave_nxt;
            if (taken) begin
                hold_r <= addr_r;
            end
        end
    end

    // secondary destinations; unassigned codes write nothing
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            disp_r <= `MAD_RST_WORD;
            cyc_r <= '0;
            check_r <= `MAD_RST_WORD;
        end else begin
            if (wr_disp) begin
                disp_r <= res;
            end
            if (wr_cyc) begin
                cyc_r <= res[WIDTH-1:0];
            end
            if (wr_check) begin
                check_r <= res;
            end
        end
    end

    // external primary destinations: one-cycle strobe with registered data
    wire [7:0] dwr_nxt = wr_ext ? (8'h01 << dcode[2:0]) : 8'h00;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dwr_r <= 8'h00;
            ddata_r <= `MAD_RST_WORD;
        end else begin
            dwr_r <= dwr_nxt;
            if (wr_ext) begin
                ddata_r <= res;
            end
        end
    end

    assign prim_dst_wr_o = dwr_r;
    assign prim_dst_data_o = ddata_r;
    assign instr_addr_o = addr_r;
    assign hold_o = hold_r;
    assign condition_flags_register_o = condition_flags_register_r;
    assign display_o = disp_r;
    assign cycle_count_o = cyc_r;
    assign check_o = check_r;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    wire [15:0] s1_rot = {s1_word[7:0], s1_word[15:8]};
    wire [15:0] acc0_plus_k = acc_r[0] + {8'h00, konst};
    wire [15:0] acc0_minus_k = acc_r[0] - {8'h00, konst};
    wire shift_left_out = s1_word[15];
    wire xfer_rot_ext = instr_valid_i && is_xfer && mode == 4'h4 && !dcode[`MAD_ACC_BIT];
    wire log2_zero_acc = instr_valid_i && fn == `MAD_FN_LOG2 && mode[2:0] == 3'h2 && dcode[`MAD_ACC_BIT];

    a_condition_flags_register_kept: assert property (instr_valid_i && upd_class && !mode[`MAD_M_UPD] && !wr_condition_flags_register
        |=> $stable(condition_flags_register_r)) else $error("condition register changed without update bit");

    a_branch_taken: assert property (taken
        |=> addr_r[7:0] == $past(konst) && addr_r[15:8] == $past(addr_r[15:8]) && hold_r == $past(addr_r))
        else $error("taken branch address or hold wrong");

    a_branch_skip: assert property (instr_valid_i && is_branch && !bsel[dcode]
        |=> addr_r == $past(addr_step) && $stable(hold_r)) else $error("untaken branch altered sequencing");

    a_const_upper: assert property (instr_valid_i && fn == `MAD_FN_LDK1 && !dcode[`MAD_ACC_BIT]
        |=> prim_dst_data_o == {8'h00, $past(konst)}) else $error("constant load left upper bits");

    a_xfer_rotate: assert property (xfer_rot_ext
        |=> prim_dst_data_o == $past(s1_rot) && prim_dst_wr_o != 8'h00) else $error("rotate transfer wrong");

    a_shift_save: assert property (instr_valid_i && is_shift && !mode[`MAD_M_OPT]
        |=> shsave_r == $past(shift_left_out)) else $error("shift save bit not retained");

    a_addk_sum: assert property (instr_valid_i && fn == `MAD_FN_ADDK && !dcode[`MAD_ACC_BIT]
        |=> prim_dst_data_o == $past(acc0_plus_k)) else $error("add constant sum wrong");

    a_subk_diff: assert property (instr_valid_i && fn == `MAD_FN_SUBK && !dcode[`MAD_ACC_BIT]
        |=> prim_dst_data_o == $past(acc0_minus_k)) else $error("subtract constant difference wrong");

    a_zero_flag: assert property (log2_zero_acc && mode[`MAD_M_UPD] && !wr_condition_flags_register
        |=> condition_flags_register_r[`MAD_C_ZERO] && acc_r[$past(dcode[2:0])] == 16'h0000) else $error("zero result not flagged");

    a_strobe_pulse: assert property (prim_dst_wr_o != 8'h00 && !wr_ext
        |=> prim_dst_wr_o == 8'h00) else $error("destination strobe held too long");
endmodule

// *** testbench/mad_rom_model.sv ***
// microprogram store model: hands out the word held at the current microprogram address
// assumes the bench fills each word through put() before the datapath executes it
`timescale 1ns/1ps

module mad_rom_model (
    input wire mad_pkg::mad_word_t addr_i,
    output mad_pkg::mad_word_t word_o
);
    import mad_pkg::*;
    mad_word_t mem [256];

    // unfilled places hold an inert code, so a stray fetch only steps the address
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'hFFFF;
        end
    end

    // only the low address byte indexes the store; higher pages alias on purpose
    assign word_o = mem[addr_i[7:0]];

    task put(input logic [7:0] a, input mad_word_t w);
        mem[a] = w;
    endtask
endmodule

// *** testbench/microcode_alu_datapath_bench.sv ***
// self-checking bench of the execution datapath, fed from the store model
// assumes mad_pkg and the design files compiled first; inputs change 1 ns after the rising edge
`timescale 1ns/1ps

module microcode_alu_datapath_bench;
    import mad_pkg::*;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [6:0][15:0] prim_src_i = '0;
    mad_word_t instr_i, console_mode_i = 16'h0000, exp_addr = 16'h0000, exp_hold = 16'h0000, sv;
    logic serial_in_i = 1'b1, parity_even_i = 1'b0, frame_ready_i = 1'b0, zero_frame_i = 1'b0;
    logic test_true_i = 1'b0;
    logic [7:0] prim_dst_wr_o;
    mad_word_t prim_dst_data_o, instr_addr_o, hold_o, condition_flags_register_o, display_o, cycle_count_o, check_o;
    int failures = 0;
    int check_count = 0;
    // shift cases: mode, source, result; the fill-save rows lean on the row before them
    logic [3:0] sh_m [8] = '{4'h8, 4'h2, 4'h6, 4'h1, 4'h6, 4'h5, 4'h7, 4'h4};
    mad_word_t sh_in [8] = '{16'h8001, 16'h0000, 16'h4000, 16'h8001, 16'h0000, 16'h8001, 16'h0000, 16'h0003};
    mad_word_t sh_ex [8] = '{16'h0002, 16'h0001, 16'h2000, 16'h0003, 16'h8000, 16'hC000, 16'h8000, 16'h0001};
    // arithmetic cases: word, accumulator, source, result; carry-hold rows follow a flag update
    logic [63:0] ar [15] = '{64'h4003_1234_0100_1334, 64'h4000_1234_0100_1335, 64'h4004_1234_0100_0101,
        64'h4007_1234_0100_00FF, 64'h400A_FFFF_0002_0002, 64'h4001_1234_0100_1335,
        64'h400B_0001_0001_0002, 64'h4001_1234_0100_1334, 64'h5000_1234_0100_1134,
        64'h5003_1234_0100_1133, 64'h5004_1234_0100_FF00, 64'h5002_1234_0100_1134,
        64'h8020_12F0_0000_1310, 64'h9020_12F0_0000_12D0, 64'hA0AB_FFFF_0000_00AB};

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    mad_rom_model u_rom (.addr_i(instr_addr_o), .word_o(instr_i));

    mad_datapath dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .prim_src_i(prim_src_i), .console_mode_i(console_mode_i), .serial_in_i(serial_in_i),
        .parity_even_i(parity_even_i), .frame_ready_i(frame_ready_i), .zero_frame_i(zero_frame_i),
        .test_true_i(test_true_i), .prim_dst_wr_o(prim_dst_wr_o), .prim_dst_data_o(prim_dst_data_o),
        .instr_addr_o(instr_addr_o), .hold_o(hold_o), .condition_flags_register_o(condition_flags_register_o), .display_o(display_o),
        .cycle_count_o(cycle_count_o), .check_o(check_o));

    function automatic mad_word_t iw(input logic [3:0] f, input logic [3:0] d, input logic [3:0] s,
                                     input logic [3:0] m);
        return {f, d, s, m};
    endfunction

    // logic results worked out independently of the design
    function automatic mad_word_t lg(input logic [3:0] c, input mad_word_t a, input mad_word_t s);
        case (c)
            4'h0: return a ^ s;
            4'h1: return ~(a & s);
            4'h2: return a & ~s;
            4'h3: return ~s;
            4'h4: return a | s;
            4'h5: return 16'hFFFF;
            4'h6: return a;
            4'h7: return a | ~s;
            4'h8: return ~a & s;
            4'h9: return ~a;
            4'hA: return 16'h0000;
            4'hB: return ~(a | s);
            4'hC: return s;
            4'hD: return ~a | s;
            4'hE: return a & s;
            default: return ~(a ^ s);
        endcase
    endfunction

    task chk(input mad_word_t got, input mad_word_t exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one instruction; kind 0 steps the address, 1 is a taken branch, 2 loads the address with v
    // valid stays high on return, so the caller issues the next word or goes idle before the edge
    task exec(input mad_word_t w, input int kind = 0, input mad_word_t v = 16'h0000);
        mad_word_t old;
        old = exp_addr;
        u_rom.put(old[7:0], w);
        instr_valid_i = 1'b1;
        @(posedge clk_i);
        #1;
        if (kind == 1) begin
            exp_hold = old;
            exp_addr = {old[15:8], w[7:0]};
        end else begin
            exp_addr = (kind == 2) ? v : old + 16'h0001;
        end
        chk(instr_addr_o, exp_addr, "address");
        chk(hold_o, exp_hold, "hold");
    endtask

    task pd(input int code, input mad_word_t v);
        chk({8'h00, prim_dst_wr_o}, 16'h0001 << code, "strobe");
        chk(prim_dst_data_o, v, "dest data");
    endtask

    task setacc(input logic [2:0] n, input mad_word_t v);
        prim_src_i[0] = v;
        exec(iw(4'h0, {1'b1, n}, 4'h0, 4'h0));
    endtask

    task final_report;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        chk(instr_addr_o | hold_o | condition_flags_register_o | display_o | cycle_count_o | check_o | prim_dst_data_o, 16'h0000, "reset");
        for (int d = 0; d < 8; d++) begin
            sv = {4{4'(d + 1)}};
            prim_src_i[d % 7] = sv;
            exec(iw(4'h0, 4'(d), 4'(d % 7), 4'h0));
            pd(d, sv);
        end
        // transfer paths and byte rotation
        prim_src_i[0] = 16'h12AB;
        console_mode_i = 16'h5A3C;
        exec(iw(4'h0, 4'h0, 4'h0, 4'h4));
        pd(0, 16'hAB12);
        exec(iw(4'h0, 4'h1, 4'h3, 4'h1));
        pd(1, 16'h5A3C);
        exec(iw(4'h0, 4'h2, 4'h0, 4'h2));
        chk(display_o, 16'h12AB, "display");
        exec(iw(4'h0, 4'h8, 4'h3, 4'h3));
        chk(check_o, 16'h5A3C, "check reg");
        exec(iw(4'h0, 4'h3, 4'h3, 4'h7));
        chk(cycle_count_o, 16'h3C5A, "cycle count");
        exec(iw(4'h0, 4'h5, 4'h0, 4'h2));
        chk(display_o ^ check_o ^ cycle_count_o, 16'h12AB ^ 16'h5A3C ^ 16'h3C5A, "unassigned");
        chk({8'h00, prim_dst_wr_o}, 16'h0000, "no strobe");
        // flag update only with mode bit 3
        prim_src_i[0] = 16'h0000;
        exec(iw(4'h0, 4'h0, 4'h0, 4'h8));
        chk(condition_flags_register_o & 16'h6000, 16'h6000, "flags set");
        prim_src_i[0] = 16'h8000;
        exec(iw(4'h0, 4'h0, 4'h0, 4'h0));
        chk(condition_flags_register_o & 16'h6000, 16'h6000, "flags kept");
        exec(iw(4'h0, 4'h0, 4'h0, 4'h8));
        chk(condition_flags_register_o & 16'h6000, 16'h0000, "flags clear");
        for (int i = 0; i < 8; i++) begin
            prim_src_i[0] = sh_in[i];
            exec(iw(4'h3, 4'h0, 4'h0, sh_m[i]));
            pd(0, sh_ex[i]);
        end
        chk(condition_flags_register_o & 16'hE000, 16'hC000, "shift save");
        // the second accumulator must never stand in for the first
        setacc(3'h1, 16'h7777);
        for (int i = 0; i < 15; i++) begin
            setacc(3'h0, ar[i][47:32]);
            prim_src_i[0] = ar[i][31:16];
            exec(ar[i][63:48]);
            pd(0, ar[i][15:0]);
        end
        exec(iw(4'h0, 4'h0, 4'h9, 4'h0));
        pd(0, 16'h7777);
        setacc(3'h0, 16'h0F0F);
        prim_src_i[0] = 16'h00FF;
        for (int c = 0; c < 16; c++) begin
            exec(iw(4'h6 + 4'(c / 8), 4'h0, 4'h0, 4'(c % 8)));
            pd(0, lg(4'(c), 16'h0F0F, 16'h00FF));
        end
        // all-zeros result into an accumulator with the update bit raises the zero flag
        setacc(3'h2, 16'h5555);
        exec(iw(4'h7, 4'hA, 4'h0, 4'hA));
        chk(condition_flags_register_o & 16'h6000, 16'h6000, "zero flag");
        exec(iw(4'h0, 4'h0, 4'hA, 4'h0));
        pd(0, 16'h0000);
        exec(16'hB2C5);
        chk(display_o, 16'h00C5, "constant d2");
        // branches from a high page, every selector both ways except the unassigned 2, 3, 5, 6, never taken
        prim_src_i[0] = 16'h3400;
        exec(iw(4'h0, 4'h0, 4'h0, 4'h2), 2, 16'h3400);
        for (int p = 0; p < 2; p++) begin
            sv = p ? 16'hE400 : 16'h0000;
            prim_src_i[0] = sv;
            exec(iw(4'h0, 4'h1, 4'h0, 4'h2));
            chk(condition_flags_register_o, sv, "condition_flags_register load");
            prim_src_i[0] = p ? 16'hFFFF : 16'h0000;
            exec(iw(4'h0, 4'h3, 4'h0, 4'h2));
            {parity_even_i, frame_ready_i, zero_frame_i, test_true_i} = {4{p[0]}};
            for (int s = 0; s < 16; s++) begin
                sv = p ? 16'h7693 : 16'h8900;
                exec({4'hC, 4'(s), 4'h6, 4'(s)}, sv[s]);
            end
        end
        // idle cycle leaves everything as it was
        instr_valid_i = 1'b0;
        @(posedge clk_i);
        #1;
        chk(instr_addr_o, exp_addr, "idle address");
        chk({8'h00, prim_dst_wr_o}, 16'h0000, "idle strobe");
        // second reset in mid-run
        arst_n_i = 1'b0;
        #20;
        chk(instr_addr_o | hold_o | condition_flags_register_o | display_o | check_o, 16'h0000, "reset again");
        // release again off the edge; the first word after release must run normally
        @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        exp_addr = 16'h0000;
        exp_hold = 16'h0000;
        exec(16'hA305);
        pd(3, 16'h0005);
        final_report();
    end
endmodule
